// ==== common/alarm_pkg.sv ====
// Package with register map, field layout and reset values of the alarm monitor.
package alarm_pkg;

   // ********************************************************************
   // Register byte offsets
   // ********************************************************************
   localparam logic [7:0] OUTPUT_CONTROL_OFF = 8'h00;
   localparam logic [7:0] RESET_POWER_CONTROL_OFF = 8'h04;
   localparam logic [7:0] DATA_OUTPUT_CONTROL_OFF = 8'h08;
   localparam logic [7:0] HIGH_THRESHOLD_OFF = 8'h0c;
   localparam logic [7:0] LOW_THRESHOLD_OFF = 8'h10;
   localparam logic [7:0] ALARM_FLAG_OFF = 8'h14;
   localparam logic [7:0] IRQ_STATUS_OFF = 8'h18;
   localparam logic [7:0] IRQ_MASK_OFF = 8'h1c;
   localparam logic [7:0] LAST_CODE_OFF = 8'h20;

   // ********************************************************************
   // Field layout
   // ********************************************************************
   localparam int CODE_W = 16;
   localparam int HYST_W = 8;
   localparam int HYST_LSB = 16;
   localparam int FLAG_N = 4;
   localparam int SEL_W = 2;
   localparam int INPUT_DIS_BIT = 0;
   localparam int SUPPLY_DIS_BIT = 1;
   localparam int TRIP_LSB = 4;
   localparam int FRAME_W = 32;
   localparam int IRQ_W = 3;
   // Flag order within a nibble.
   localparam int IN_HIGH = 0;
   localparam int IN_LOW = 1;
   localparam int SUP_HIGH = 2;
   localparam int SUP_LOW = 3;
   // Interrupt status bits.
   localparam int IRQ_TRIP = 0;
   localparam int IRQ_EOC = 1;
   localparam int IRQ_FRAME = 2;

   // ********************************************************************
   // Encodings and reset values
   // ********************************************************************
   localparam logic [1:0] SEL_ALARM = 2'h1;
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic [15:0] HIGH_TH_RESET = 16'hffff;
   localparam logic [15:0] LOW_TH_RESET = 16'h0000;
   localparam logic [7:0] HYST_RESET = 8'h00;
   localparam logic [7:0] APPEND_RESET = 8'h00;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

endpackage : alarm_pkg

// ==== hw/alarm_frame_shifter.sv ====
// Serial frame shifter: 32-bit in/out shift register framed by the convert/select pin.
`timescale 1ns/1ps
module alarm_frame_shifter #(
   parameter int WIDTH = 32
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic convert_select_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   input wire logic [WIDTH-1:0] load_word_i,
   output logic sdo_o,
   output logic frame_start_o,
   output logic frame_end_o,
   output logic [WIDTH-1:0] rx_word_o
);

   // ********************************************************************
   // Pin synchronisers
   // ********************************************************************
   // The first stage is read only by the second; edges come from stage two and three.
   logic [2:0] cs_sync;
   logic [2:0] sclk_sync;
   logic [1:0] sdi_sync;
   logic [WIDTH-1:0] shift;
   logic in_frame;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cs_sync <= 3'h7;
         sclk_sync <= 3'h0;
         sdi_sync <= 2'h0;
      end else begin
         cs_sync <= {cs_sync[1:0], convert_select_n_i};
         sclk_sync <= {sclk_sync[1:0], sclk_i};
         sdi_sync <= {sdi_sync[0], sdi_i};
      end
   end

   wire cs_fall = cs_sync[2] & ~cs_sync[1];
   wire cs_rise = ~cs_sync[2] & cs_sync[1];
   wire sclk_rise = ~sclk_sync[2] & sclk_sync[1];
   wire sclk_fall = sclk_sync[2] & ~sclk_sync[1];

   // ********************************************************************
   // Shift register
   // ********************************************************************
   // Capture on the rising clock edge, launch the next bit on the falling edge.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         shift <= '0;
         in_frame <= 1'b0;
         sdo_o <= 1'b0;
         frame_start_o <= 1'b0;
         frame_end_o <= 1'b0;
         rx_word_o <= '0;
      end else begin
         frame_start_o <= cs_fall;
         frame_end_o <= cs_rise & in_frame;
         if (cs_fall) begin
            shift <= load_word_i;
            sdo_o <= load_word_i[WIDTH-1];
            in_frame <= 1'b1;
         end else if (cs_rise) begin
            in_frame <= 1'b0;
            rx_word_o <= shift;
         end else if (in_frame && sclk_rise) begin
            shift <= {shift[WIDTH-2:0], sdi_sync[1]};
         end else if (in_frame && sclk_fall) begin
            sdo_o <= shift[WIDTH-1];
         end
      end
   end

endmodule : alarm_frame_shifter

// ==== hw/adc_alarm_monitor.sv ====
// Alarm monitor of a converter: thresholds, flags, alarm pin, APB registers and serial frame.
`timescale 1ns/1ps
// Function
// - The alarm pin carries the alarm only while the secondary output select is 01b.
// - With alarms on, input and supply alarms are enabled unless their disable bits are set.
// - Each alarm source has an active flag and a tripped flag, both set on a trigger.
// - Active flags are recomputed at each end of conversion and hold only if still alarming.
// - Tripped flags stay set until the alarm flag register is read, which clears them.
// - All flags update at each end of conversion and are readable in any serial frame.
// - The alarm pin is high while an input or supply over- or undervoltage exists.
// - Alarm flags selected in the data output control register are appended to the word.
// - The input high alarm sets when the code is strictly above the high threshold.
// - The input high alarm clears once the code is at most threshold minus hysteresis minus 1.
// - The input low alarm sets when the code is strictly below the low threshold.
// - The input low alarm clears once the code is at least threshold plus hysteresis plus 1.
// - High and low thresholds are independent and share one hysteresis value.
// - Supply high and low alarms follow the 5.3 V and 4.7 V comparator indications.
// - The serial port acts as a 32-bit shift register shifting in and out together.
// - A frame lasts from convert/select low to its next rise, which starts a conversion.
module adc_alarm_monitor (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Converter core
   input wire logic [15:0] conv_code_i,
   input wire logic conv_done_i,
   output logic conv_start_o,
   // Supply comparators, asynchronous
   input wire logic supply_over_i,
   input wire logic supply_under_i,
   // Serial pins
   input wire logic convert_select_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   output logic sdo_o,
   // Multifunction pin and interrupt
   output logic multifunction_output_pin_o,
   output logic irq_o
);

   // ********************************************************************
   // Configuration registers
   // ********************************************************************
   logic [alarm_pkg::SEL_W-1:0] secondary_output_select;
   logic input_alarm_disable;
   logic supply_alarm_disable;
   logic [2*alarm_pkg::FLAG_N-1:0] append_select;
   logic [alarm_pkg::CODE_W-1:0] high_threshold;
   logic [alarm_pkg::CODE_W-1:0] low_threshold;
   logic [alarm_pkg::HYST_W-1:0] hysteresis;
   logic [alarm_pkg::FLAG_N-1:0] active_flag;
   logic [alarm_pkg::FLAG_N-1:0] tripped_flag;
   logic [alarm_pkg::IRQ_W-1:0] irq_status;
   logic [alarm_pkg::IRQ_W-1:0] irq_mask;
   logic [alarm_pkg::CODE_W-1:0] last_code;
   logic [1:0] over_sync;
   logic [1:0] under_sync;

   // ********************************************************************
   // APB decode
   // ********************************************************************
   // An access is taken once; the registered pready then blocks a second take of it.
   wire access = psel_i & penable_i & ~pready_o;
   wire wr = access & pwrite_i;
   wire rd = access & ~pwrite_i;
   wire hit_out_ctl = paddr_i == alarm_pkg::OUTPUT_CONTROL_OFF;
   wire hit_rst_pwr = paddr_i == alarm_pkg::RESET_POWER_CONTROL_OFF;
   wire hit_data_ctl = paddr_i == alarm_pkg::DATA_OUTPUT_CONTROL_OFF;
   wire hit_high = paddr_i == alarm_pkg::HIGH_THRESHOLD_OFF;
   wire hit_low = paddr_i == alarm_pkg::LOW_THRESHOLD_OFF;
   wire hit_flag = paddr_i == alarm_pkg::ALARM_FLAG_OFF;
   wire hit_status = paddr_i == alarm_pkg::IRQ_STATUS_OFF;
   wire hit_mask = paddr_i == alarm_pkg::IRQ_MASK_OFF;
   wire hit_code = paddr_i == alarm_pkg::LAST_CODE_OFF;
   wire hit_any = hit_out_ctl | hit_rst_pwr | hit_data_ctl | hit_high | hit_low | hit_flag
      | hit_status | hit_mask | hit_code;
   wire flag_read = rd & hit_flag;

   wire [31:0] threshold_high_word = {8'h00, hysteresis, high_threshold};
   wire [31:0] threshold_low_word = {8'h00, hysteresis, low_threshold};
   wire [31:0] flag_word = {24'h000000, tripped_flag, active_flag};
   wire [31:0] read_mux =
      hit_out_ctl ? {30'h00000000, secondary_output_select} :
      hit_rst_pwr ? {30'h00000000, supply_alarm_disable, input_alarm_disable} :
      hit_data_ctl ? {24'h000000, append_select} :
      hit_high ? threshold_high_word :
      hit_low ? threshold_low_word :
      hit_flag ? flag_word :
      hit_status ? {29'h00000000, irq_status} :
      hit_mask ? {29'h00000000, irq_mask} :
      hit_code ? {16'h0000, last_code} : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h00000000;
      end else begin
         pready_o <= access;
         pslverr_o <= access & ~hit_any;
         prdata_o <= rd ? read_mux : 32'h00000000;
      end
   end

   // ********************************************************************
   // Register writes
   // ********************************************************************
   // A write to either threshold register updates the one shared hysteresis.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         secondary_output_select <= alarm_pkg::SEL_RESET;
         input_alarm_disable <= 1'b0;
         supply_alarm_disable <= 1'b0;
         append_select <= alarm_pkg::APPEND_RESET;
         high_threshold <= alarm_pkg::HIGH_TH_RESET;
         low_threshold <= alarm_pkg::LOW_TH_RESET;
         hysteresis <= alarm_pkg::HYST_RESET;
         irq_mask <= alarm_pkg::IRQ_MASK_RESET;
      end else if (wr) begin
         if (hit_out_ctl) begin
            secondary_output_select <= pwdata_i[alarm_pkg::SEL_W-1:0];
         end
         if (hit_rst_pwr) begin
            input_alarm_disable <= pwdata_i[alarm_pkg::INPUT_DIS_BIT];
            supply_alarm_disable <= pwdata_i[alarm_pkg::SUPPLY_DIS_BIT];
         end
         if (hit_data_ctl) begin
            append_select <= pwdata_i[2*alarm_pkg::FLAG_N-1:0];
         end
         if (hit_high) begin
            high_threshold <= pwdata_i[alarm_pkg::CODE_W-1:0];
         end
         if (hit_low) begin
            low_threshold <= pwdata_i[alarm_pkg::CODE_W-1:0];
         end
         if (hit_high || hit_low) begin
            hysteresis <= pwdata_i[alarm_pkg::HYST_LSB +: alarm_pkg::HYST_W];
         end
         if (hit_mask) begin
            irq_mask <= pwdata_i[alarm_pkg::IRQ_W-1:0];
         end
      end
   end

   // ********************************************************************
   // Supply comparator synchronisers
   // ********************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         over_sync <= 2'h0;
         under_sync <= 2'h0;
      end else begin
         over_sync <= {over_sync[0], supply_over_i};
         under_sync <= {under_sync[0], supply_under_i};
      end
   end

   // ********************************************************************
   // Threshold comparison
   // ********************************************************************
   // Limits are one bit wider and release points two bits wider so that threshold minus hysteresis cannot wrap.
   wire alarm_on = secondary_output_select == alarm_pkg::SEL_ALARM;
   wire input_en = alarm_on & ~input_alarm_disable;
   wire supply_en = alarm_on & ~supply_alarm_disable;
   wire [alarm_pkg::CODE_W:0] code_x = {1'b0, conv_code_i};
   wire [alarm_pkg::CODE_W:0] hyst_x = {{(alarm_pkg::CODE_W - alarm_pkg::HYST_W + 1){1'b0}},
      hysteresis};
   wire [alarm_pkg::CODE_W:0] high_x = {1'b0, high_threshold};
   wire [alarm_pkg::CODE_W:0] low_x = {1'b0, low_threshold};
   wire [alarm_pkg::CODE_W+1:0] high_release = {1'b0, high_x} - {1'b0, hyst_x}
      - {{(alarm_pkg::CODE_W+1){1'b0}}, 1'b1};
   wire [alarm_pkg::CODE_W+1:0] low_release = {1'b0, low_x} + {1'b0, hyst_x}
      + {{(alarm_pkg::CODE_W+1){1'b0}}, 1'b1};
   // A negative high release point means the code can never fall far enough.
   wire high_set = code_x > high_x;
   wire high_clr = ~high_release[alarm_pkg::CODE_W+1]
      & ({1'b0, code_x} <= high_release);
   wire low_set = code_x < low_x;
   wire low_clr = {1'b0, code_x} >= low_release;

   // Between the set and release points an input alarm keeps its last state.
   wire next_in_high = high_set | (active_flag[alarm_pkg::IN_HIGH] & ~high_clr);
   wire next_in_low = low_set | (active_flag[alarm_pkg::IN_LOW] & ~low_clr);

   logic [alarm_pkg::FLAG_N-1:0] next_active;
   always_comb begin
      next_active = '0;
      next_active[alarm_pkg::IN_HIGH] = input_en & next_in_high;
      next_active[alarm_pkg::IN_LOW] = input_en & next_in_low;
      next_active[alarm_pkg::SUP_HIGH] = supply_en & over_sync[1];
      next_active[alarm_pkg::SUP_LOW] = supply_en & under_sync[1];
   end

   // ********************************************************************
   // Alarm flags
   // ********************************************************************
   // Tripped bits: a new trigger in the cycle of the clearing read wins.
   logic [alarm_pkg::FLAG_N-1:0] next_tripped;
   always_comb begin
      next_tripped = tripped_flag;
      if (flag_read) begin
         next_tripped = '0;
      end
      if (conv_done_i) begin
         next_tripped = next_tripped | next_active;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         active_flag <= '0;
         tripped_flag <= '0;
         last_code <= '0;
         multifunction_output_pin_o <= 1'b0;
      end else begin
         tripped_flag <= next_tripped;
         if (conv_done_i) begin
            active_flag <= next_active;
            last_code <= conv_code_i;
            multifunction_output_pin_o <= alarm_on & (|next_active);
         end else if (!alarm_on) begin
            multifunction_output_pin_o <= 1'b0;
         end
      end
   end

   // ********************************************************************
   // Serial frame
   // ********************************************************************
   // Selected flags follow the code; unselected flag bits go out as zero.
   wire [2*alarm_pkg::FLAG_N-1:0] all_flags = {tripped_flag, active_flag};
   wire [2*alarm_pkg::FLAG_N-1:0] append_bits = all_flags & append_select;
   wire [alarm_pkg::FRAME_W-1:0] frame_word = {last_code, append_bits,
      {(alarm_pkg::FRAME_W - alarm_pkg::CODE_W - 2*alarm_pkg::FLAG_N){1'b0}}};
   logic frame_start;
   logic frame_end;

   alarm_frame_shifter #(
      .WIDTH(alarm_pkg::FRAME_W)
   ) u_shifter (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .convert_select_n_i(convert_select_n_i),
      .sclk_i(sclk_i),
      .sdi_i(sdi_i),
      .load_word_i(frame_word),
      .sdo_o(sdo_o),
      .frame_start_o(frame_start),
      .frame_end_o(frame_end),
      .rx_word_o()
   );

   // ********************************************************************
   // Conversion start and interrupts
   // ********************************************************************
   logic [alarm_pkg::IRQ_W-1:0] events;
   always_comb begin
      events = '0;
      events[alarm_pkg::IRQ_TRIP] = conv_done_i & (|(next_active & ~active_flag));
      events[alarm_pkg::IRQ_EOC] = conv_done_i;
      events[alarm_pkg::IRQ_FRAME] = frame_start;
   end

   wire [alarm_pkg::IRQ_W-1:0] status_clear = (wr & hit_status) ?
      pwdata_i[alarm_pkg::IRQ_W-1:0] : '0;
   wire [alarm_pkg::IRQ_W-1:0] next_status = (irq_status & ~status_clear) | events;

   // Masking gates only the output; status bits keep recording while masked.

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         irq_status <= '0;
         irq_o <= 1'b0;
         conv_start_o <= 1'b0;
      end else begin
         irq_status <= next_status;
         irq_o <= |(next_status & irq_mask);
         conv_start_o <= frame_end;
      end
   end

endmodule : adc_alarm_monitor

// ==== bench/alarm_monitor_assertions.sv ====
// Checker of the alarm monitor port behaviour.
`timescale 1ns/1ps
module alarm_monitor_assertions (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [15:0] conv_code_i,
   input wire logic conv_done_i,
   input wire logic conv_start_o,
   input wire logic convert_select_n_i,
   input wire logic multifunction_output_pin_o,
   input wire logic irq_o
);
   // ********
   // Shadow registers
   // ********
   // A write lands on the edge that takes the access, so the shadow follows that same edge.
   logic [1:0] sel;
   logic [15:0] hi_th;
   logic [15:0] lo_th;
   logic [1:0] dis;
   logic [2:0] mask;
   wire wr = psel_i & penable_i & pwrite_i & ~pready_o;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sel <= 2'h0;
         hi_th <= 16'hffff;
         lo_th <= 16'h0000;
         dis <= 2'h0;
         mask <= 3'h0;
      end else if (wr) begin
         if (paddr_i == 8'h00) sel <= pwdata_i[1:0];
         if (paddr_i == 8'h04) dis <= pwdata_i[1:0];
         if (paddr_i == 8'h0c) hi_th <= pwdata_i[15:0];
         if (paddr_i == 8'h10) lo_th <= pwdata_i[15:0];
         if (paddr_i == 8'h1c) mask <= pwdata_i[2:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence apb_take;
      psel_i && penable_i && !pready_o;
   endsequence
   sequence input_armed;
      conv_done_i && sel == 2'h1 && !dis[0];
   endsequence
   chk_ready_next: assert property (apb_take |=> pready_o) else $error("pready late");
   chk_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready held");
   chk_unmapped_err: assert property (apb_take and paddr_i > 8'h20 |=> pslverr_o)
      else $error("no slave error");
   chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("stray data");
   chk_high_set: assert property (input_armed and conv_code_i > hi_th
      |-> ##2 multifunction_output_pin_o) else $error("high alarm missing");
   chk_low_set: assert property (input_armed and conv_code_i < lo_th
      |-> ##2 multifunction_output_pin_o) else $error("low alarm missing");
   chk_pin_sel_off: assert property ((sel != 2'h1) [*3] |-> !multifunction_output_pin_o)
      else $error("pin alarm while deselected");
   chk_pin_all_off: assert property (conv_done_i && dis == 2'h3
      |-> ##2 !multifunction_output_pin_o) else $error("pin alarm while disabled");
   chk_start_after: assert property ($rose(convert_select_n_i) |-> ##[2:8] conv_start_o)
      else $error("no conversion start");
   chk_irq_masked: assert property ((mask == 3'h0) [*2] |-> !irq_o) else $error("masked irq");
endmodule : alarm_monitor_assertions

bind adc_alarm_monitor alarm_monitor_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .conv_code_i(conv_code_i), .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
   .convert_select_n_i(convert_select_n_i), .irq_o(irq_o),
   .multifunction_output_pin_o(multifunction_output_pin_o));

// ==== bench/serial_host_model.sv ====
// Host controller model that runs serial frames against the monitor.
`timescale 1ns/1ps
module serial_host_model (
   input wire logic clk_i,
   input wire logic sdo_i,
   output logic convert_select_n_o,
   output logic sclk_o,
   output logic sdi_o
);
   logic cs_n = 1'b1;
   logic sclk = 1'b0;
   logic tx_bit = 1'b0;
   logic in_frame = 1'b0;
   logic idle = 1'b0;
   // Outside a frame the data line toggles so a stale bit never passes for data.
   always_ff @(posedge clk_i) begin
      idle <= ~idle;
   end
   assign convert_select_n_o = cs_n;
   assign sclk_o = sclk;
   assign sdi_o = in_frame ? tx_bit : idle;
   // ********
   // Frame
   // ********
   // Clock halves of five cycles stay above the four-cycle minimum of the sampler.
   task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
      logic [31:0] sh;
      sh = tx;
      @(posedge clk_i);
      cs_n <= 1'b0;
      in_frame <= 1'b1;
      tx_bit <= sh[31];
      repeat (6) @(posedge clk_i);
      for (int i = 31; i >= 0; i--) begin
         sclk <= 1'b1;
         rx[i] = sdo_i;
         repeat (5) @(posedge clk_i);
         sclk <= 1'b0;
         sh = sh << 1;
         tx_bit <= sh[31];
         repeat (5) @(posedge clk_i);
      end
      cs_n <= 1'b1;
      in_frame <= 1'b0;
      repeat (12) @(posedge clk_i);
   endtask : frame
endmodule : serial_host_model

// ==== bench/adc_alarm_monitor_bench.sv ====
// Self-checking bench of the alarm monitor.
`timescale 1ns/1ps
module adc_alarm_monitor_bench;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] code = 16'h0;
   logic done = 1'b0;
   logic s_over = 1'b0;
   logic s_under = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic sdo;
   logic pin;
   logic irq;
   logic [31:0] rd;
   logic err;
   int bad_count = 0;
   int tests_run = 0;
   always #5 clk_i = ~clk_i;
   adc_alarm_monitor u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .conv_code_i(code),
      .conv_done_i(done), .conv_start_o(), .supply_over_i(s_over), .supply_under_i(s_under),
      .convert_select_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo),
      .multifunction_output_pin_o(pin), .irq_o(irq));
   serial_host_model u_host (.clk_i(clk_i), .sdo_i(sdo), .convert_select_n_o(cs_n),
      .sclk_o(sclk), .sdi_o(sdi));
   // ********
   // Shared tasks
   // ********
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) begin
         n++;
         if (n > 16) begin
            check("apb wait", 32'h1, 32'h0);
            end_of_test();
         end
         @(posedge clk_i);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic conv(input logic [15:0] c);
      @(posedge clk_i);
      code <= c;
      done <= 1'b1;
      @(posedge clk_i);
      done <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : conv
   task automatic step(input logic [15:0] c, input logic [3:0] act);
      conv(c);
      check("alarm pin", {31'h0, pin}, {31'h0, |act});
      apb(1'b0, 8'h14, 32'h0);
      check("active flags", rd & 32'hf, {28'h0, act});
   endtask : step
   // ********
   // Scenarios
   // ********
   task automatic t_reset();
      logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, offs[i], 32'h0);
         check("reset value", rd, (i == 3) ? 32'h0000ffff : 32'h0);
      end
      apb(1'b0, 8'h24, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      $display("done: reset");
   endtask : t_reset
   task automatic t_hyst();
      logic [15:0] cs [8] = '{16'h1000, 16'h1001, 16'h0fe0, 16'h0fdf,
                             16'h0100, 16'h00ff, 16'h0120, 16'h0121};
      logic [3:0] act [8] = '{4'h0, 4'h1, 4'h1, 4'h0, 4'h0, 4'h2, 4'h2, 4'h0};
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h0c, 32'h0010_1000);
      apb(1'b1, 8'h10, 32'h0020_0100);
      apb(1'b0, 8'h0c, 32'h0);
      check("shared hysteresis", rd, 32'h0020_1000);
      for (int i = 0; i < 8; i++) begin
         step(cs[i], act[i]);
         apb(1'b0, 8'h20, 32'h0);
         check("last code", rd, {16'h0, cs[i]});
      end
      $display("done: thresholds");
   endtask : t_hyst
   task automatic t_trip();
      conv(16'h2000);
      conv(16'h0800);
      apb(1'b0, 8'h14, 32'h0);
      check("tripped kept", rd, 32'h10);
      apb(1'b0, 8'h14, 32'h0);
      check("tripped cleared", rd, 32'h0);
      $display("done: tripped");
   endtask : t_trip
   task automatic t_supply();
      s_over <= 1'b1;
      repeat (4) @(posedge clk_i);
      step(16'h0800, 4'h4);
      s_over <= 1'b0;
      s_under <= 1'b1;
      repeat (4) @(posedge clk_i);
      step(16'h0800, 4'h8);
      apb(1'b1, 8'h04, 32'h2);
      step(16'h0800, 4'h0);
      apb(1'b1, 8'h04, 32'h3);
      step(16'h2000, 4'h0);
      apb(1'b1, 8'h04, 32'h0);
      s_under <= 1'b0;
      repeat (4) @(posedge clk_i);
      step(16'h0800, 4'h0);
      $display("done: supply");
   endtask : t_supply
   task automatic t_select();
      apb(1'b1, 8'h00, 32'h0);
      conv(16'h2000);
      check("pin deselected", {31'h0, pin}, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      step(16'h2000, 4'h1);
      step(16'h0800, 4'h0);
      $display("done: select");
   endtask : t_select
   task automatic t_frame();
      logic [31:0] rx;
      s_over <= 1'b1;
      apb(1'b1, 8'h08, 32'h03);
      conv(16'h1234);
      u_host.frame(32'ha5a5_0f0f, rx);
      check("frame active", rx, 32'h1234_0100);
      apb(1'b1, 8'h08, 32'hf0);
      u_host.frame(32'h5a5a_f0f0, rx);
      check("frame tripped", rx, 32'h1234_5000);
      s_over <= 1'b0;
      $display("done: frame");
   endtask : t_frame
   task automatic t_irq();
      apb(1'b1, 8'h18, 32'h7);
      apb(1'b1, 8'h1c, 32'h2);
      repeat (3) @(posedge clk_i);
      check("irq idle", {31'h0, irq}, 32'h0);
      conv(16'h0800);
      check("irq raised", {31'h0, irq}, 32'h1);
      apb(1'b1, 8'h18, 32'h2);
      repeat (3) @(posedge clk_i);
      check("irq cleared", {31'h0, irq}, 32'h0);
      apb(1'b1, 8'h1c, 32'h0);
      conv(16'h0800);
      check("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      check("status sticky", rd, 32'h2);
      conv(16'h2000);
      apb(1'b0, 8'h18, 32'h0);
      check("trip status", rd, 32'h3);
      $display("done: interrupt");
   endtask : t_irq
   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_hyst();
      t_trip();
      t_supply();
      t_select();
      t_frame();
      t_irq();
      end_of_test();
   end
endmodule : adc_alarm_monitor_bench
